//--- src/dps_defines.svh
// Constants for the drive power state machine
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
`define DPS_CW_SO_BIT     0
`define DPS_CW_EV_BIT     1
`define DPS_CW_QS_BIT     2
`define DPS_CW_EO_BIT     3
`define DPS_CW_FR_BIT     7
`define DPS_OFS_CTRL      8'h00
`define DPS_OFS_STATE     8'h04
`define DPS_OFS_IRQ_STAT  8'h08
`define DPS_OFS_IRQ_CLR   8'h0C
`define DPS_OFS_IRQ_EN    8'h10
`define DPS_CTRL_RESET    16'h0000
`define DPS_IRQ_W         4
`define DPS_INIT_NS       1000
`define DPS_CLK_NS        20
`define DPS_INIT_CYC      ((`DPS_INIT_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`endif

//--- src/dps_pkg.sv
// Types for the drive power state machine
package dps_pkg;
    typedef enum logic [2:0] {
        DPS_NOT_READY  = 3'b000,
        DPS_SW_DIS     = 3'b001,
        DPS_READY      = 3'b010,
        DPS_SW_ON      = 3'b011,
        DPS_OP_EN      = 3'b100,
        DPS_QSTOP      = 3'b101,
        DPS_FLT_REACT  = 3'b110,
        DPS_FAULT      = 3'b111
    } dps_state_t;

    typedef struct packed {
        logic shutdown;
        logic switch_on;
        logic disable_voltage;
        logic quick_stop;
        logic disable_op;
        logic enable_op;
        logic fault_reset;
    } dps_cmd_t;

    typedef struct packed {
        logic network_operation_mode;
        logic net_command_interface_select;
        logic comm_run_command_source_zero;
    } dps_enable_t;
endpackage

//--- src/dps_cmd_decode.sv
// Controlword command decoder with fault-reset edge detection
`timescale 1ns/1ps
`include "dps_defines.svh"
module dps_cmd_decode (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic [15:0]       i_cw,
    input  wire logic              i_cw_valid,
    output dps_pkg::dps_cmd_t      o_cmd
);
    logic fr_prev_r;
    logic so;
    logic ev;
    logic qs;
    logic eo;
    logic fr;

    assign so = i_cw[`DPS_CW_SO_BIT];
    assign ev = i_cw[`DPS_CW_EV_BIT];
    assign qs = i_cw[`DPS_CW_QS_BIT];
    assign eo = i_cw[`DPS_CW_EO_BIT];
    assign fr = i_cw[`DPS_CW_FR_BIT];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fr_prev_r <= 1'b0;
        end else if (i_cw_valid) begin
            fr_prev_r <= fr;
        end
    end

    // Commands only count on a cyclic update
    always_comb begin
        o_cmd.shutdown        = i_cw_valid & ~fr & qs & ev & ~so;
        o_cmd.switch_on       = i_cw_valid & ~fr & ~eo & qs & ev & so;
        o_cmd.disable_voltage = i_cw_valid & ~fr & ~ev;
        o_cmd.quick_stop      = i_cw_valid & ~fr & ~qs & ev;
        o_cmd.disable_op      = i_cw_valid & ~fr & ~eo & qs & ev & so;
        o_cmd.enable_op       = i_cw_valid & ~fr & eo & qs & ev & so;
        o_cmd.fault_reset     = i_cw_valid & fr & ~fr_prev_r;
    end
endmodule

//--- src/dps_irq.sv
// Sticky event status with enable mask and level interrupt
`timescale 1ns/1ps
`include "dps_defines.svh"
module dps_irq (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_b,
    input  wire logic [`DPS_IRQ_W-1:0]  i_event,
    input  wire logic [`DPS_IRQ_W-1:0]  i_clr,
    input  wire logic                   i_clr_we,
    input  wire logic [`DPS_IRQ_W-1:0]  i_en,
    output logic      [`DPS_IRQ_W-1:0]  o_status,
    output logic                        o_irq
);
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status <= '0;
        end else begin
            // A new event wins over a clear in the same cycle
            o_status <= (o_status & ~(i_clr_we ? i_clr : '0)) | i_event;
        end
    end

    assign o_irq = |(o_status & i_en);
endmodule

//--- src/dps_top.sv
// Drive power state machine with register port
`timescale 1ns/1ps
`include "dps_defines.svh"
module dps_top #(
    parameter int INIT_CYC = `DPS_INIT_CYC
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic [15:0]  i_cw,
    input  wire logic         i_cw_cyclic,
    input  wire logic         i_cw_acyclic,
    input  wire logic         i_pdo_operational,
    input  wire logic         i_position_control,
    input  wire logic         i_motor_stopped,
    input  wire logic         i_dc_brake_active,
    input  wire logic         i_pre_excitation_active,
    input  wire logic         i_positioning_busy,
    input  wire logic         i_stop_input_assigned,
    input  wire logic         i_output_shutoff_ext,
    input  wire logic         i_fault_detect,
    input  wire logic         i_fault_serious,
    input  wire dps_pkg::dps_enable_t i_net_en,
    input  wire logic [7:0]   i_addr,
    input  wire logic [15:0]  i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic      [15:0]  o_rdata,
    output logic [2:0]        o_state,
    output logic              o_output_ready_flag,
    output logic              o_servo_on_input,
    output logic              o_run_start,
    output logic              o_quick_stop_active,
    output logic              o_fault_active,
    output logic              o_irq
);
    dps_pkg::dps_state_t state_r;
    dps_pkg::dps_state_t state_nxt;
    dps_pkg::dps_cmd_t   cmd;
    logic [15:0]         ctrl_r;
    logic [`DPS_IRQ_W-1:0] irq_en_r;
    logic [`DPS_IRQ_W-1:0] irq_status;
    logic [`DPS_IRQ_W-1:0] irq_event;
    logic [15:0]         init_cnt_r;
    logic                init_done;
    logic                net_ok;
    logic                qs_cmd_used_r;
    logic                fault_latched_r;
    logic                serious_latched_r;
    logic                enable_r;
    logic                cancel_run;
    logic                braking;
    logic                ready_prev_r;
    logic                cw_valid;

    // Acyclic controlword writes never reach the decoder
    assign cw_valid = i_cw_cyclic & i_pdo_operational & ~i_cw_acyclic;

    dps_cmd_decode u_dec (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_cw       (i_cw),
        .i_cw_valid (cw_valid),
        .o_cmd      (cmd)
    );

    assign net_ok  = i_net_en.network_operation_mode & i_net_en.net_command_interface_select
                   & i_net_en.comm_run_command_source_zero;
    assign braking = i_dc_brake_active | i_pre_excitation_active;

    // Initialization timer
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            init_cnt_r <= 16'h0000;
        end else if (state_r == dps_pkg::DPS_NOT_READY && !init_done) begin
            init_cnt_r <= init_cnt_r + 16'h0001;
        end
    end
    assign init_done = (init_cnt_r >= 16'(INIT_CYC));

    // Quick stop command seen since reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            qs_cmd_used_r <= 1'b0;
        end else if (cmd.quick_stop) begin
            // Once used, quick stop is no longer blocked by assigned stop inputs
            qs_cmd_used_r <= 1'b1;
        end
    end

    // Serious faults persist until reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fault_latched_r   <= 1'b0;
            serious_latched_r <= 1'b0;
        end else begin
            if (i_fault_detect) begin
                fault_latched_r <= 1'b1;
            end else if (state_r == dps_pkg::DPS_FAULT && cmd.fault_reset && !serious_latched_r) begin
                fault_latched_r <= 1'b0;
            end
            if (i_fault_detect && i_fault_serious) begin
                serious_latched_r <= 1'b1;
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dps_pkg::DPS_NOT_READY: begin
                if (init_done) begin
                    state_nxt = dps_pkg::DPS_SW_DIS;
                end
            end
            dps_pkg::DPS_SW_DIS: begin
                if (net_ok) begin
                    if (cmd.enable_op) begin
                        state_nxt = dps_pkg::DPS_OP_EN;
                    end else if (cmd.switch_on) begin
                        state_nxt = dps_pkg::DPS_SW_ON;
                    end else if (cmd.shutdown) begin
                        state_nxt = dps_pkg::DPS_READY;
                    end
                end
            end
            dps_pkg::DPS_READY: begin
                if (!net_ok || cmd.disable_voltage || cmd.quick_stop) begin
                    state_nxt = dps_pkg::DPS_SW_DIS;
                end else if (cmd.enable_op) begin
                    state_nxt = dps_pkg::DPS_OP_EN;
                end else if (cmd.switch_on) begin
                    state_nxt = dps_pkg::DPS_SW_ON;
                end
            end
            dps_pkg::DPS_SW_ON: begin
                if (!net_ok || cmd.disable_voltage || cmd.quick_stop) begin
                    state_nxt = dps_pkg::DPS_SW_DIS;
                end else if (cmd.shutdown) begin
                    state_nxt = dps_pkg::DPS_READY;
                end else if (cmd.enable_op && o_output_ready_flag) begin
                    state_nxt = dps_pkg::DPS_OP_EN;
                end
            end
            dps_pkg::DPS_OP_EN: begin
                if (!net_ok || cmd.disable_voltage) begin
                    state_nxt = dps_pkg::DPS_SW_DIS;
                end else if (cmd.quick_stop && (qs_cmd_used_r || !i_stop_input_assigned)) begin
                    state_nxt = dps_pkg::DPS_QSTOP;
                end else if (cmd.shutdown) begin
                    state_nxt = dps_pkg::DPS_READY;
                end else if (!o_output_ready_flag) begin
                    state_nxt = dps_pkg::DPS_SW_ON;
                end else if (enable_r && i_motor_stopped && !braking) begin
                    state_nxt = dps_pkg::DPS_SW_ON;
                end
            end
            dps_pkg::DPS_QSTOP: begin
                if (!net_ok || cmd.disable_voltage) begin
                    state_nxt = dps_pkg::DPS_SW_DIS;
                end else if (i_position_control && !i_positioning_busy) begin
                    state_nxt = dps_pkg::DPS_SW_DIS;
                end else if (!i_position_control && i_motor_stopped && !braking) begin
                    state_nxt = dps_pkg::DPS_SW_DIS;
                end
            end
            dps_pkg::DPS_FLT_REACT: begin
                state_nxt = dps_pkg::DPS_FAULT;
            end
            dps_pkg::DPS_FAULT: begin
                if (cmd.fault_reset && !serious_latched_r) begin
                    state_nxt = dps_pkg::DPS_SW_DIS;
                end
            end
        endcase
        if (i_fault_detect && state_r != dps_pkg::DPS_FAULT && state_r != dps_pkg::DPS_FLT_REACT) begin
            state_nxt = dps_pkg::DPS_FLT_REACT;
        end
    end

    // Pending disable operation: held until motor stop allows the return
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_r <= 1'b0;
        end else if (state_r != dps_pkg::DPS_OP_EN || state_nxt != dps_pkg::DPS_OP_EN) begin
            enable_r <= 1'b0;
        end else if (cmd.disable_op) begin
            enable_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= dps_pkg::DPS_NOT_READY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Transitions 5, 8, 9, 12 and 14 drop the run condition
    assign cancel_run = (state_r == dps_pkg::DPS_OP_EN && state_nxt != dps_pkg::DPS_OP_EN)
                      || (state_r == dps_pkg::DPS_QSTOP && state_nxt != dps_pkg::DPS_QSTOP)
                      || (state_r == dps_pkg::DPS_FLT_REACT);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_servo_on_input    <= 1'b0;
            o_run_start         <= 1'b0;
            o_output_ready_flag <= 1'b0;
            ready_prev_r        <= 1'b0;
        end else begin
            if (cancel_run) begin
                o_servo_on_input <= 1'b0;
                o_run_start      <= 1'b0;
            end else if (state_nxt == dps_pkg::DPS_OP_EN && state_r != dps_pkg::DPS_OP_EN) begin
                o_servo_on_input <= i_position_control;
                o_run_start      <= ~i_position_control;
            end
            o_output_ready_flag <= (state_nxt == dps_pkg::DPS_SW_ON || state_nxt == dps_pkg::DPS_OP_EN)
                                 & ~i_output_shutoff_ext;
            ready_prev_r <= o_output_ready_flag;
        end
    end

    assign o_state             = state_r;
    assign o_quick_stop_active = (state_r == dps_pkg::DPS_QSTOP);
    assign o_fault_active      = fault_latched_r;

    // Events: fault, quick stop entry, enabled entry, output ready drop
    assign irq_event = {ready_prev_r & ~o_output_ready_flag,
                        state_nxt == dps_pkg::DPS_OP_EN && state_r != dps_pkg::DPS_OP_EN,
                        state_nxt == dps_pkg::DPS_QSTOP && state_r != dps_pkg::DPS_QSTOP,
                        state_nxt == dps_pkg::DPS_FLT_REACT && state_r != dps_pkg::DPS_FLT_REACT};

    dps_irq u_irq (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        .i_event  (irq_event),
        .i_clr    (i_wdata[`DPS_IRQ_W-1:0]),
        .i_clr_we (i_wr && i_addr == `DPS_OFS_IRQ_CLR),
        .i_en     (irq_en_r),
        .o_status (irq_status),
        .o_irq    (o_irq)
    );

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_r   <= `DPS_CTRL_RESET;
            irq_en_r <= '0;
        end else if (i_wr) begin
            if (i_addr == `DPS_OFS_IRQ_EN) begin
                irq_en_r <= i_wdata[`DPS_IRQ_W-1:0];
            end
            if (i_addr == `DPS_OFS_CTRL) begin
                ctrl_r <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            unique case (i_addr)
                `DPS_OFS_CTRL:     o_rdata <= ctrl_r;
                `DPS_OFS_STATE:    o_rdata <= {13'h0000, state_r};
                `DPS_OFS_IRQ_STAT: o_rdata <= {12'h000, irq_status};
                `DPS_OFS_IRQ_EN:   o_rdata <= {12'h000, irq_en_r};
                default:           o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule

//--- test/dps_master.sv
// Fieldbus master model sending cyclic controlword frames
`timescale 1ns/1ps
module dps_master (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_send,
    input  wire logic [15:0] i_word,
    output logic      [15:0] o_cw,
    output logic             o_cw_cyclic
);
    // Between frames the word keeps toggling so a stale value never looks like a command
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cw        <= 16'hA5A5;
            o_cw_cyclic <= 1'b0;
        end else if (i_send) begin
            o_cw        <= i_word;
            o_cw_cyclic <= 1'b1;
        end else begin
            o_cw        <= ~o_cw;
            o_cw_cyclic <= 1'b0;
        end
    end
endmodule

//--- test/dps_top_sva.sv
// Port-level assertions for the drive power state machine
`timescale 1ns/1ps
module dps_top_sva #(
    parameter int INIT_CYC = 2
) (
    input wire logic                 i_clk,
    input wire logic                 i_rst_b,
    input wire logic [15:0]          i_cw,
    input wire logic                 i_cw_cyclic,
    input wire logic                 i_cw_acyclic,
    input wire logic                 i_pdo_operational,
    input wire logic                 i_fault_detect,
    input wire logic                 i_fault_serious,
    input wire logic                 i_stop_input_assigned,
    input wire dps_pkg::dps_enable_t i_net_en,
    input wire logic [2:0]           o_state,
    input wire logic                 o_output_ready_flag,
    input wire logic                 o_servo_on_input,
    input wire logic                 o_run_start,
    input wire logic                 o_quick_stop_active
);
    logic       take;
    logic       calm;
    logic [7:0] init_cnt_r;
    assign take = i_cw_cyclic && i_pdo_operational && !i_cw_acyclic;
    assign calm = (i_net_en == 3'h7) && !i_fault_detect;
    // Saturates so a stuck state cannot wrap back under the limit
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) init_cnt_r <= 8'h00;
        else if (o_state == 3'h0 && init_cnt_r != 8'hFF) init_cnt_r <= init_cnt_r + 8'h01;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    init_exit_a: assert property (init_cnt_r <= INIT_CYC + 2)
        else $error("init phase too long");
    enable_gate_a: assert property (o_state == 3'h3 && !o_output_ready_flag |=> o_state != 3'h4)
        else $error("enable taken while not ready");
    enable_take_a: assert property (o_state == 3'h3 && o_output_ready_flag && take && calm && !i_cw[7]
        && i_cw[3:0] == 4'hF |=> o_state == 3'h4) else $error("enable command lost");
    qstop_entry_a: assert property (o_state == 3'h4 && take && calm && !i_cw[7] && i_cw[2:1] == 2'h1
        && !i_stop_input_assigned |=> o_state == 3'h5) else $error("quick stop not entered");
    qstop_flag_a: assert property (o_quick_stop_active == (o_state == 3'h5))
        else $error("quick stop flag wrong");
    ready_low_a: assert property (o_state inside {3'h0, 3'h1, 3'h2, 3'h7} ##1
        o_state inside {3'h0, 3'h1, 3'h2, 3'h7} |-> !o_output_ready_flag) else $error("ready flag high");
    servo_cancel_a: assert property ((o_state inside {3'h1, 3'h2, 3'h3, 3'h7})[*2]
        |-> !o_servo_on_input && !o_run_start) else $error("run condition not cancelled");
    net_force_a: assert property (o_state inside {3'h2, 3'h3, 3'h4, 3'h5} && i_net_en != 3'h7
        && !i_fault_detect |=> o_state == 3'h1) else $error("network loss not forced");
    fault_seq_a: assert property (o_state inside {[3'h1:3'h5]} && i_fault_detect
        |=> o_state == 3'h6 ##1 o_state == 3'h7) else $error("fault sequence wrong");
    serious_hold_a: assert property (o_state == 3'h7 && i_fault_serious && i_net_en == 3'h7
        |=> o_state == 3'h7) else $error("serious fault cleared");
    cyc_only_a: assert property (o_state == 3'h1 && !take && calm |=> o_state == 3'h1)
        else $error("state moved without cyclic word");
    cover property (o_state == 3'h4);
    cover property (o_state == 3'h5);
    cover property (o_state == 3'h7);
endmodule

//--- test/dps_top_bench.sv
// Self-checking bench for the drive power state machine
`timescale 1ns/1ps
module dps_top_bench;
    logic                clk = 1'b0;
    logic                rst_b = 1'b0;
    logic                send = 1'b0;
    logic [15:0]         word = 16'h0000;
    logic [15:0]         cw;
    logic                cw_cyclic;
    logic                acyc = 1'b0;
    logic                pdo = 1'b1;
    logic                stop_asg = 1'b0;
    logic                pos_ctl = 1'b0;
    logic                motor_stop = 1'b1;
    logic                dc_brake = 1'b0;
    logic                pre_exc = 1'b0;
    logic                pbusy = 1'b0;
    logic                shutoff = 1'b0;
    logic                fault = 1'b0;
    logic                serious = 1'b0;
    dps_pkg::dps_enable_t net_en = 3'h7;
    logic [7:0]          addr = 8'h00;
    logic [15:0]         wdata = 16'h0000;
    logic                wr_s = 1'b0;
    logic                rd_s = 1'b0;
    logic [15:0]         rdata;
    logic [2:0]          st;
    logic                flag, servo, run, qsa, fact, irq;
    int                  n_errors = 0;
    int                  checks_done = 0;

    always #10 clk = ~clk;

    dps_master u_master (.i_clk(clk), .i_rst_b(rst_b), .i_send(send), .i_word(word), .o_cw(cw),
        .o_cw_cyclic(cw_cyclic));
    dps_top #(.INIT_CYC(2)) u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_cw(cw), .i_cw_cyclic(cw_cyclic),
        .i_cw_acyclic(acyc), .i_pdo_operational(pdo), .i_position_control(pos_ctl),
        .i_motor_stopped(motor_stop), .i_dc_brake_active(dc_brake), .i_pre_excitation_active(pre_exc),
        .i_positioning_busy(pbusy), .i_stop_input_assigned(stop_asg), .i_output_shutoff_ext(shutoff),
        .i_fault_detect(fault), .i_fault_serious(serious), .i_net_en(net_en), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_state(st),
        .o_output_ready_flag(flag), .o_servo_on_input(servo), .o_run_start(run),
        .o_quick_stop_active(qsa), .o_fault_active(fact), .o_irq(irq));

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [15:0] w);
        @(posedge clk);
        send <= 1'b1;
        word <= w;
        @(posedge clk);
        send <= 1'b0;
    endtask
    // Waits for a move, or with stay set gives the state time to move wrongly
    task automatic see(input logic [2:0] exp, input bit stay);
        int n = 0;
        if (stay) repeat (6) @(posedge clk);
        #1;
        while (!stay && st !== exp && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(st), 16'(exp));
        if (n == 20) close_out();
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge clk);
        chk(16'(st), 16'h0000);
        rst_b <= 1'b1;
        see(3'h1, 0);
        rdc(8'h00, 16'h0000);
        wr(8'h00, 16'h1234);
        rdc(8'h00, 16'h1234);
        rdc(8'h04, 16'h0001);
        rdc(8'h20, 16'h0000);
        wr(8'h10, 16'h0001);
        rdc(8'h10, 16'h0001);
        cmd(16'h0006);
        see(3'h2, 0);
        cmd(16'h0007);
        see(3'h3, 0);
        chk(16'(flag), 16'h0001);
        cmd(16'h000F);
        see(3'h4, 0);
        chk(16'(run), 16'h0001);
        chk(16'(irq), 16'h0000);
        // Commanded disable must wait out motion and braking
        @(posedge clk) motor_stop <= 1'b0;
        cmd(16'h0007);
        see(3'h4, 1);
        @(posedge clk) dc_brake <= 1'b1;
        @(posedge clk) motor_stop <= 1'b1;
        see(3'h4, 1);
        @(posedge clk) dc_brake <= 1'b0;
        see(3'h3, 0);
        chk(16'(run), 16'h0000);
        @(posedge clk) shutoff <= 1'b1;
        see(3'h3, 1);
        chk(16'(flag), 16'h0000);
        cmd(16'h000F);
        see(3'h3, 1);
        @(posedge clk) shutoff <= 1'b0;
        cmd(16'h000F);
        see(3'h4, 0);
        @(posedge clk) shutoff <= 1'b1;
        see(3'h3, 0);
        chk(16'(run), 16'h0000);
        @(posedge clk) shutoff <= 1'b0;
        cmd(16'h0000);
        see(3'h1, 0);
        @(posedge clk) pos_ctl <= 1'b1;
        @(posedge clk) pbusy <= 1'b1;
        cmd(16'h000F);
        see(3'h4, 0);
        chk(16'(servo), 16'h0001);
        cmd(16'h0002);
        see(3'h5, 0);
        chk(16'(qsa), 16'h0001);
        see(3'h5, 1);
        @(posedge clk) pbusy <= 1'b0;
        see(3'h1, 0);
        chk(16'(servo), 16'h0000);
        @(posedge clk) pos_ctl <= 1'b0;
        cmd(16'h000F);
        see(3'h4, 0);
        @(posedge clk) motor_stop <= 1'b0;
        cmd(16'h0002);
        see(3'h5, 1);
        @(posedge clk) pre_exc <= 1'b1;
        @(posedge clk) motor_stop <= 1'b1;
        see(3'h5, 1);
        @(posedge clk) pre_exc <= 1'b0;
        see(3'h1, 0);
        cmd(16'h0007);
        see(3'h3, 0);
        @(posedge clk) net_en <= 3'h3;
        see(3'h1, 0);
        cmd(16'h0006);
        see(3'h1, 1);
        @(posedge clk) net_en <= 3'h7;
        cmd(16'h0006);
        see(3'h2, 0);
        cmd(16'h0002);
        see(3'h1, 0);
        @(posedge clk) acyc <= 1'b1;
        cmd(16'h0006);
        see(3'h1, 1);
        @(posedge clk) acyc <= 1'b0;
        pdo <= 1'b0;
        cmd(16'h0006);
        see(3'h1, 1);
        @(posedge clk) pdo <= 1'b1;
        rdc(8'h08, 16'h000E);
        wr(8'h0C, 16'h000F);
        @(posedge clk) fault <= 1'b1;
        @(posedge clk) fault <= 1'b0;
        see(3'h7, 0);
        chk(16'(fact), 16'h0001);
        chk(16'(irq), 16'h0001);
        rdc(8'h08, 16'h0001);
        wr(8'h0C, 16'h0001);
        rdc(8'h08, 16'h0000);
        chk(16'(irq), 16'h0000);
        cmd(16'h0000);
        cmd(16'h0080);
        see(3'h1, 0);
        @(posedge clk) serious <= 1'b1;
        @(posedge clk) fault <= 1'b1;
        @(posedge clk) fault <= 1'b0;
        see(3'h7, 0);
        cmd(16'h0000);
        cmd(16'h0080);
        see(3'h7, 1);
        @(posedge clk) rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        serious <= 1'b0;
        rst_b <= 1'b1;
        see(3'h1, 0);
        chk(16'(fact), 16'h0000);
        // Stop input assigned and quick stop not yet used: entry is blocked
        @(posedge clk) stop_asg <= 1'b1;
        cmd(16'h000F);
        see(3'h4, 0);
        cmd(16'h0002);
        see(3'h4, 1);
        cmd(16'h0002);
        see(3'h5, 0);
        close_out();
    end
endmodule

bind dps_top dps_top_sva #(.INIT_CYC(INIT_CYC)) u_sva (.i_clk, .i_rst_b, .i_cw, .i_cw_cyclic, .i_cw_acyclic,
    .i_pdo_operational, .i_fault_detect, .i_fault_serious, .i_stop_input_assigned, .i_net_en, .o_state,
    .o_output_ready_flag,
    .o_servo_on_input, .o_run_start, .o_quick_stop_active);
